// ==== src/flcfg_regs.sv ====
// Summary of operation
// [RULE1] select bit 7: 0 hold, 1 reset
// [RULE2] pin role applies only with quad off
// [RULE3] quad on: pin is data, no hold/reset
// [RULE4] drive field 6:5, default 01 full
// [RULE5] scheme 0: range fields protect array
// [RULE6] scheme 1: per-block lock bits protect
// [RULE7] all block locks set after reset
// [RULE8] 36h locks, 39h unlocks one block
// [RULE9] depth 0: b9h acts as 79h
// [RULE10] ultra-deep entry discards sram buffer
// [RULE11] depth 1: b9h deep, sram kept
// [RULE12] only abh wakes from power-down
// [RULE13] chip select toggles do not wake
// [RULE14] read-only program mode flag present
// [RULE15] flag bit 6, 0 byte/page default
// [RULE16] reserved bits read zero, writes ignored
// [RULE17] config changes only via accepted write
module flcfg_regs
   import flcfg_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire flcfg_cmd_t cmd_in,
   input wire flcfg_sr_write_t sr_write_in,
   input wire logic quad_lines_enable_in,
   input wire logic cs_n_in,
   input wire logic seq_prog_enter_in,
   input wire logic seq_prog_exit_in,
   output logic [7:0] pin_drive_protect_config_out,
   output logic [7:0] power_program_mode_config_out,
   output logic hold_enable_out,
   output logic reset_enable_out,
   output logic [1:0] output_drive_strength_out,
   output logic range_protect_active_out,
   output logic block_protect_active_out,
   output logic [FLCFG_NUM_BLOCKS-1:0] block_write_protect_out,
   output logic power_down_out,
   output logic ultra_deep_sleep_out,
   output logic sram_discard_out
);
   logic hold_reset_sel_q;
   logic [1:0] drive_q;
   logic scheme_q;
   logic pd_depth_q;
   logic seq_prog_q;
   flcfg_pd_state_t pd_state_q;
   logic [FLCFG_NUM_BLOCKS-1:0] locked;
   logic awake;
   logic cmd_live;
   logic sr_live;
   logic lock_cmd;
   logic unlock_cmd;
   logic enter_ultra;
   logic enter_deep;
   logic chk_live_q;

   assign awake = (pd_state_q == FLCFG_PD_ACTIVE);
   assign cmd_live = cmd_in.valid && awake;
   assign sr_live = sr_write_in.valid && awake;
   assign lock_cmd = cmd_live && scheme_q && (cmd_in.opcode == FLCFG_OP_BLOCK_LOCK); // RULE8
   assign unlock_cmd = cmd_live && scheme_q && (cmd_in.opcode == FLCFG_OP_BLOCK_UNLOCK); // RULE8
   assign enter_ultra = cmd_live && ((cmd_in.opcode == FLCFG_OP_ULTRA_DEEP) ||
      ((cmd_in.opcode == FLCFG_OP_POWER_DOWN) && !pd_depth_q)); // RULE9
   assign enter_deep = cmd_live && (cmd_in.opcode == FLCFG_OP_POWER_DOWN) && pd_depth_q; // RULE11

   // pin, drive and protection config bits
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         hold_reset_sel_q <= FLCFG_HOLD_RESET_RST;
         drive_q <= FLCFG_DRIVE_RST;
         scheme_q <= FLCFG_SCHEME_RST;
      end else if (sr_live && sr_write_in.sel == FLCFG_SEL_PIN_DRIVE) begin // RULE17
         hold_reset_sel_q <= sr_write_in.data[FLCFG_HOLD_RESET_BIT]; // RULE1
         drive_q <= sr_write_in.data[FLCFG_DRIVE_HI_BIT:FLCFG_DRIVE_LO_BIT]; // RULE4
         scheme_q <= sr_write_in.data[FLCFG_SCHEME_BIT];
      end
   end

   // power-down depth bit
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pd_depth_q <= FLCFG_PD_DEPTH_RST;
      end else if (sr_live && sr_write_in.sel == FLCFG_SEL_POWER_PROG) begin // RULE17
         pd_depth_q <= sr_write_in.data[FLCFG_PD_DEPTH_BIT];
      end
   end

   // program mode flag, hardware owned
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         seq_prog_q <= FLCFG_SEQ_PROG_RST; // RULE15
      end else if (seq_prog_enter_in) begin
         seq_prog_q <= 1'b1; // RULE14
      end else if (seq_prog_exit_in) begin
         seq_prog_q <= 1'b0;
      end
   end

   // power-down state; chip select alone never wakes
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pd_state_q <= FLCFG_PD_ACTIVE;
      end else begin
         case (pd_state_q)
            FLCFG_PD_ACTIVE: begin
               if (enter_ultra) begin
                  pd_state_q <= FLCFG_PD_ULTRA; // RULE9
               end else if (enter_deep) begin
                  pd_state_q <= FLCFG_PD_DEEP; // RULE11
               end
            end
            FLCFG_PD_DEEP, FLCFG_PD_ULTRA: begin
               if (cmd_in.valid && cmd_in.opcode == FLCFG_OP_WAKE) begin // RULE13
                  pd_state_q <= FLCFG_PD_ACTIVE; // RULE12
               end
            end
            default: begin
               pd_state_q <= FLCFG_PD_ACTIVE;
            end
         endcase
      end
   end

   // sram discard pulse on ultra-deep entry
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sram_discard_out <= 1'b0;
      end else begin
         sram_discard_out <= enter_ultra; // RULE10
      end
   end

   flcfg_block_locks u_locks (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .lock_in(lock_cmd),
      .unlock_in(unlock_cmd),
      .block_in(cmd_in.block),
      .locked_out(locked)
   );

   // registered views and derived controls
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pin_drive_protect_config_out <= 8'h00;
         power_program_mode_config_out <= 8'h00;
         hold_enable_out <= 1'b0;
         reset_enable_out <= 1'b0;
         output_drive_strength_out <= FLCFG_DRIVE_RST;
         range_protect_active_out <= 1'b0;
         block_protect_active_out <= 1'b0;
         block_write_protect_out <= '0;
         power_down_out <= 1'b0;
         ultra_deep_sleep_out <= 1'b0;
      end else begin
         pin_drive_protect_config_out <= {hold_reset_sel_q, drive_q, 2'b00, scheme_q, 2'b00}; // RULE16
         power_program_mode_config_out <= {pd_depth_q, seq_prog_q, 6'h00}; // RULE15
         hold_enable_out <= !quad_lines_enable_in && !hold_reset_sel_q; // RULE2
         reset_enable_out <= !quad_lines_enable_in && hold_reset_sel_q; // RULE3
         output_drive_strength_out <= drive_q; // RULE4
         range_protect_active_out <= !scheme_q; // RULE5
         block_protect_active_out <= scheme_q; // RULE6
         block_write_protect_out <= scheme_q ? locked : '0; // RULE6
         power_down_out <= !awake;
         ultra_deep_sleep_out <= (pd_state_q == FLCFG_PD_ULTRA);
      end
   end

   // checks start one edge after reset release, once outputs follow live state
   always_ff @(posedge clk_in) begin
      chk_live_q <= resetn_in;
   end

   AST_QUAD_DISABLES_PIN: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE3
      quad_lines_enable_in |=> !hold_enable_out && !reset_enable_out)
      else $error("pin function active with quad enabled");
   AST_PIN_ROLE: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE1
      !quad_lines_enable_in |=> (reset_enable_out == $past(hold_reset_sel_q)) &&
      (hold_enable_out != reset_enable_out))
      else $error("pin role does not follow select");
   AST_DRIVE_WRITE: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE4
      sr_live && sr_write_in.sel == FLCFG_SEL_PIN_DRIVE |=> ##1 output_drive_strength_out == $past(sr_write_in.data[6:5], 2))
      else $error("drive strength not updated by write");
   AST_RESERVED_ZERO: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE16
      pin_drive_protect_config_out[4:3] == 2'b00 && pin_drive_protect_config_out[1:0] == 2'b00)
      else $error("reserved bits read non-zero");
   AST_NO_STRAY_CHANGE: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE17
      !sr_write_in.valid |=> $stable(drive_q) && $stable(scheme_q) && $stable(pd_depth_q) && $stable(hold_reset_sel_q))
      else $error("config changed without write");
   AST_B9_ULTRA: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE9
      awake && cmd_in.valid && cmd_in.opcode == FLCFG_OP_POWER_DOWN && !pd_depth_q |=>
      ##1 ultra_deep_sleep_out && sram_discard_out == 1'b0)
      else $error("b9h with depth 0 did not enter ultra-deep");
   AST_DISCARD_ON_ULTRA: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE10
      enter_ultra |=> sram_discard_out)
      else $error("no sram discard on ultra-deep entry");
   AST_B9_DEEP: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE11
      enter_deep |=> pd_state_q == FLCFG_PD_DEEP && !sram_discard_out)
      else $error("b9h with depth 1 wrong mode");
   AST_WAKE_ONLY_AB: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE12
      !awake && !(cmd_in.valid && cmd_in.opcode == FLCFG_OP_WAKE) |=> !awake)
      else $error("left power-down without wake command");
   AST_CS_NO_WAKE: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE13
      !awake && $rose(cs_n_in) && !cmd_in.valid |=> ##1 power_down_out)
      else $error("chip select toggle woke device");
   AST_LOCK_CMD: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE8
      lock_cmd |=> ##1 block_write_protect_out[$past(cmd_in.block, 2)])
      else $error("block lock not applied");
   AST_UNLOCK_CMD: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE8
      unlock_cmd |=> ##1 !block_write_protect_out[$past(cmd_in.block, 2)])
      else $error("block unlock not applied");
   AST_LOCKS_RESET: assert property (@(posedge clk_in) // RULE7
      !resetn_in |=> locked == '1)
      else $error("block locks not set by reset");
   AST_SCHEME_RANGE: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE5
      !scheme_q |=> range_protect_active_out && block_write_protect_out == '0)
      else $error("range scheme not in effect");
   AST_SEQ_FLAG: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE14
      seq_prog_enter_in |=> ##1 power_program_mode_config_out[FLCFG_SEQ_PROG_BIT])
      else $error("program mode flag not set");
   AST_SEQ_CLEAR: assert property (@(posedge clk_in) disable iff (!resetn_in || !chk_live_q) // RULE15
      seq_prog_exit_in && !seq_prog_enter_in |=> ##1 !power_program_mode_config_out[FLCFG_SEQ_PROG_BIT])
      else $error("program mode flag not cleared");
endmodule

// ==== src/flcfg_pkg.sv ====
package flcfg_pkg;
   // command opcodes
   localparam logic [7:0] FLCFG_OP_BLOCK_LOCK = 8'h36;
   localparam logic [7:0] FLCFG_OP_BLOCK_UNLOCK = 8'h39;
   localparam logic [7:0] FLCFG_OP_POWER_DOWN = 8'hb9;
   localparam logic [7:0] FLCFG_OP_ULTRA_DEEP = 8'h79;
   localparam logic [7:0] FLCFG_OP_WAKE = 8'hab;
   // status register selectors for the write strobe
   localparam logic [2:0] FLCFG_SEL_PIN_DRIVE = 3'h3;
   localparam logic [2:0] FLCFG_SEL_POWER_PROG = 3'h4;
   // field positions, pin/drive/protect register
   localparam int FLCFG_HOLD_RESET_BIT = 7;
   localparam int FLCFG_DRIVE_HI_BIT = 6;
   localparam int FLCFG_DRIVE_LO_BIT = 5;
   localparam int FLCFG_SCHEME_BIT = 2;
   // field positions, power/program register
   localparam int FLCFG_PD_DEPTH_BIT = 7;
   localparam int FLCFG_SEQ_PROG_BIT = 6;
   // reset values
   localparam logic FLCFG_HOLD_RESET_RST = 1'b0;
   localparam logic [1:0] FLCFG_DRIVE_RST = 2'h1;
   localparam logic FLCFG_SCHEME_RST = 1'b0;
   localparam logic FLCFG_PD_DEPTH_RST = 1'b0;
   localparam logic FLCFG_SEQ_PROG_RST = 1'b0;
   localparam logic FLCFG_LOCK_RST = 1'b1;
   // block lock array
   localparam int FLCFG_NUM_BLOCKS = 16;
   localparam int FLCFG_BLOCK_IDX_W = 4;

   typedef enum logic [1:0] {
      FLCFG_PD_ACTIVE,
      FLCFG_PD_DEEP,
      FLCFG_PD_ULTRA
   } flcfg_pd_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [FLCFG_BLOCK_IDX_W-1:0] block;
   } flcfg_cmd_t;

   typedef struct packed {
      logic valid;
      logic [2:0] sel;
      logic [7:0] data;
   } flcfg_sr_write_t;
endpackage

// ==== src/flcfg_block_locks.sv ====
module flcfg_block_locks
   import flcfg_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic lock_in,
   input wire logic unlock_in,
   input wire logic [FLCFG_BLOCK_IDX_W-1:0] block_in,
   output logic [FLCFG_NUM_BLOCKS-1:0] locked_out
);
   genvar g;
   generate
      for (g = 0; g < FLCFG_NUM_BLOCKS; g++) begin : g_lock
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               locked_out[g] <= FLCFG_LOCK_RST; // RULE7
            end else if (block_in == FLCFG_BLOCK_IDX_W'(g)) begin
               if (lock_in) begin
                  locked_out[g] <= 1'b1; // RULE8
               end else if (unlock_in) begin
                  locked_out[g] <= 1'b0; // RULE8
               end
            end
         end
      end
   endgenerate
endmodule

// ==== tb/flcfg_host_model.sv ====
module flcfg_host_model
   import flcfg_pkg::*;
(
   input wire logic clk_in,
   output flcfg_cmd_t cmd_out,
   output flcfg_sr_write_t sr_write_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_out = '0;
      sr_write_out = '0;
   end
   // one-cycle command pulse; 36h/39h lock, abh wakes
   task automatic send_cmd(input logic [7:0] op, input logic [FLCFG_BLOCK_IDX_W-1:0] blk);
      @(posedge clk_in);
      cmd_out <= '{valid: 1'b1, opcode: op, block: blk};
      @(posedge clk_in);
      cmd_out <= '0;
   endtask
   task automatic write_sr(input logic [2:0] sel, input logic [7:0] data);
      @(posedge clk_in);
      sr_write_out <= '{valid: 1'b1, sel: sel, data: data};
      @(posedge clk_in);
      sr_write_out <= '0;
   endtask
endmodule

// ==== tb/tb_flcfg_regs.sv ====
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", n, e, a); end end
module tb_flcfg_regs;
   import flcfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, resetn_in, quad, cs_n, seq_enter, seq_exit, hold_en, rst_en, rng, blk, pd, ud, disc;
   logic [7:0] sr3, sr4, d;
   logic [1:0] drv;
   logic [15:0] bwp;
   logic [31:0] seed = 32'h4e;
   flcfg_cmd_t cmd;
   flcfg_sr_write_t srw;
   int error_cnt = 0;
   int n_compared = 0;
   flcfg_host_model i_host (.clk_in(clk_in), .cmd_out(cmd), .sr_write_out(srw));
   flcfg_regs i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .cmd_in(cmd), .sr_write_in(srw),
      .quad_lines_enable_in(quad), .cs_n_in(cs_n), .seq_prog_enter_in(seq_enter), .seq_prog_exit_in(seq_exit),
      .pin_drive_protect_config_out(sr3), .power_program_mode_config_out(sr4), .hold_enable_out(hold_en),
      .reset_enable_out(rst_en), .output_drive_strength_out(drv), .range_protect_active_out(rng),
      .block_protect_active_out(blk), .block_write_protect_out(bwp), .power_down_out(pd),
      .ultra_deep_sleep_out(ud), .sram_discard_out(disc));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] exp_sr3(input logic [7:0] v);
      return v & 8'he4;
   endfunction
   task automatic settle();
      @(posedge clk_in);
      #1;
   endtask
   // one-cycle chip select toggle and program engine pulses
   task automatic pulse_pins(input logic cs_low, input logic enter, input logic leave);
      @(posedge clk_in);
      cs_n <= !cs_low;
      seq_enter <= enter;
      seq_exit <= leave;
      @(posedge clk_in);
      cs_n <= 1'b1;
      seq_enter <= 1'b0;
      seq_exit <= 1'b0;
   endtask
   task automatic sleep_test(input logic depth, input logic [7:0] op);
      logic ultra;
      ultra = !depth || op == FLCFG_OP_ULTRA_DEEP;
      i_host.write_sr(FLCFG_SEL_POWER_PROG, {depth, 7'h7f});
      i_host.send_cmd(op, 4'h0);
      #1;
      `CHK("discard", ultra, disc)
      settle();
      `CHK("pd", 1'b1, pd)
      `CHK("ultra", ultra, ud)
      pulse_pins(1'b1, 1'b0, 1'b0);
      i_host.send_cmd(FLCFG_OP_BLOCK_UNLOCK, 4'h3);
      i_host.write_sr(FLCFG_SEL_PIN_DRIVE, 8'h60);
      settle();
      `CHK("pd held", 1'b1, pd)
      i_host.send_cmd(FLCFG_OP_WAKE, 4'h0);
      settle();
      `CHK("woken", 1'b0, pd)
      `CHK("sr3 kept", 8'h04, sr3)
      `CHK("locks kept", 16'hffff, bwp)
      `CHK("sr4", {depth, 7'h0}, sr4)
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   initial begin
      repeat (4000) @(posedge clk_in);
      error_cnt++;
      wrap_up();
   end
   initial begin
      resetn_in = 1'b0;
      quad = 1'b0;
      cs_n = 1'b1;
      seq_enter = 1'b0;
      seq_exit = 1'b0;
      repeat (8) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      `CHK("sr3 rst", 8'h20, sr3)
      `CHK("sr4 rst", 8'h00, sr4)
      `CHK("hold rst", 1'b1, hold_en)
      `CHK("range rst", 1'b1, rng)
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 8'hff : 8'(xs());
         @(posedge clk_in);
         quad <= (i < 2) ? 1'b0 : 1'(xs());
         i_host.write_sr(FLCFG_SEL_PIN_DRIVE, d);
         settle();
         `CHK("sr3", exp_sr3(d), sr3)
         `CHK("drive", d[6:5], drv)
         `CHK("hold", !quad && !d[7], hold_en)
         `CHK("reset", !quad && d[7], rst_en)
         `CHK("range", !d[2], rng)
         `CHK("blocks", {16{d[2]}}, bwp)
         `CHK("scheme", d[2], blk)
      end
      @(posedge clk_in);
      quad <= 1'b0;
      i_host.write_sr(FLCFG_SEL_PIN_DRIVE, 8'h04);
      d = {4'h0, 4'(xs())};
      i_host.send_cmd(FLCFG_OP_BLOCK_UNLOCK, d[3:0]);
      settle();
      `CHK("unlock", ~(16'h1 << d[3:0]), bwp)
      i_host.send_cmd(FLCFG_OP_BLOCK_LOCK, d[3:0]);
      settle();
      `CHK("lock", 16'hffff, bwp)
      sleep_test(1'b0, FLCFG_OP_POWER_DOWN);
      sleep_test(1'b1, FLCFG_OP_POWER_DOWN);
      sleep_test(1'b1, FLCFG_OP_ULTRA_DEEP);
      pulse_pins(1'b0, 1'b1, 1'b0);
      settle();
      `CHK("seq on", 1'b1, sr4[6])
      pulse_pins(1'b0, 1'b0, 1'b1);
      settle();
      `CHK("seq off", 1'b0, sr4[6])
      i_host.send_cmd(FLCFG_OP_BLOCK_UNLOCK, 4'h0);
      @(posedge clk_in);
      resetn_in <= 1'b0;
      @(posedge clk_in);
      resetn_in <= 1'b1;
      i_host.write_sr(FLCFG_SEL_PIN_DRIVE, 8'h04);
      settle();
      `CHK("locks rst", 16'hffff, bwp)
      wrap_up();
   end
endmodule
